// *** cij_exec.sv ***
`timescale 1ns/10ps
`include "cij_map.svh"
module cij_exec
  import cij_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Instruction from fetch, valid every cycle.
  input wire cij_instr_type instr_i,
  // Data memory read data for instr_i field[7:0].
  input wire logic [7:0] mem_rdata_i,
  // Data memory address and write request.
  output logic [7:0] mem_addr_o,
  output cij_mem_wr_type mem_wr_o,
  // Architectural state.
  output logic [7:0] acc_o,
  output logic zero_o,
  output logic [11:0] pc_o,
  // High in the dummy slot after a jump.
  output logic dummy_o
);

  // Accumulator and its next value.
  logic [7:0] acc_q, acc_d;
  // Zero flag; only the two increment opcodes move it.
  logic zero_q, zero_d;
  // Program counter; the fetch path outside reads it as the next address.
  logic [11:0] pc_q, pc_d;
  // Execute slot or the dummy slot after a jump.
  cij_state_type state_q, state_d;
  // Data memory write request, held for one cycle.
  cij_mem_wr_type wr_q, wr_d;
  // Incremented memory byte, shared by both increment opcodes.
  logic [7:0] incr_sum;

  // Adds one to a byte, wrapping at the top.
  // Both increment opcodes share it so their results cannot drift apart.
  function automatic logic [7:0] incr8(input logic [7:0] v);
    incr8 = 8'(v + 8'h01);
  endfunction : incr8

  // Memory address is the low byte of the field, combinational.
  // It follows the instruction so the read data settles within the same cycle.
  assign mem_addr_o = instr_i.field[7:0];
  assign incr_sum = incr8(mem_rdata_i);

  // Next-state logic for all architectural state.
  // Accumulator and flag default to holding, the counter to the next word, the state to execute and the write to none.
  // The write request is registered, so the memory takes it one edge later.
  // An instruction in the very next cycle that reads the same byte sees the
  // old value; the fetch side must space such pairs if it needs the new one.
  always_comb begin
    acc_d = acc_q;
    zero_d = zero_q;
    pc_d = 12'(pc_q + 12'h001);
    state_d = CIJ_EXEC;
    wr_d = '0;
    wr_d.addr = instr_i.field[7:0];
    if (state_q == CIJ_DUMMY) begin
      // dummy slot idle
      // Dummy slot: the counter holds the loaded target; only the state moves, back to execute.
      pc_d = pc_q;
    end else begin
      case (instr_i.op)
        `CIJ_OP_INCR_MEM: begin
          wr_d.we = 1'b1;
          wr_d.data = incr_sum;
          zero_d = (incr_sum == 8'h00);
        end
        `CIJ_OP_INCR_ACC: begin
          // The write request stays low, so the byte keeps its value.
          // increment to accumulator
          acc_d = incr_sum;
          zero_d = (incr_sum == 8'h00);
        end
        `CIJ_OP_JUMP: begin
          // The target is fetched next, so the following slot is a bubble.
          // load target address
          pc_d = instr_i.field;
          state_d = CIJ_DUMMY;
        end
        `CIJ_OP_MOV_MEM_ACC: begin
          acc_d = mem_rdata_i;
        end
        `CIJ_OP_MOV_IMM_ACC: begin
          acc_d = instr_i.field[7:0];
        end
        `CIJ_OP_MOV_ACC_MEM: begin
          // The stored value is the accumulator as it stood before this edge.
          // accumulator to memory
          wr_d.we = 1'b1;
          wr_d.data = acc_q;
        end
        default: begin
          // Other opcodes just advance.
          acc_d = acc_q;
        end
      endcase
    end
  end

  // Registers only.
  // Synchronous reset clears all state, so a jump cut by reset leaves no dummy slot.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      acc_q <= `CIJ_ACC_RST;
      zero_q <= 1'b0;
      pc_q <= `CIJ_PC_RST;
      state_q <= CIJ_EXEC;
      wr_q <= '0;
    end else begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      pc_q <= pc_d;
      state_q <= state_d;
      wr_q <= wr_d;
    end
  end

  // Outputs from flip-flops.
  assign acc_o = acc_q;
  assign zero_o = zero_q;
  assign pc_o = pc_q;
  assign mem_wr_o = wr_q;
  assign dummy_o = (state_q == CIJ_DUMMY);

  // Checks.
  // Assertions watch only what this block drives, from one cycle after the edge
  // that takes an instruction; all but the reset check stay quiet while reset is low.
  // An instruction is live when reset is off and no dummy slot is running.
  logic live;
  assign live = resetn_i && (state_q == CIJ_EXEC);

  // A jump taken at this edge.
  sequence jump_seen_s;
    live && instr_i.op == `CIJ_OP_JUMP;
  endsequence

  // The dummy slot with no write and no flag change, then the first live cycle.
  sequence dummy_slot_s;
    dummy_o && !mem_wr_o.we && $stable(zero_o)
      ##1 !dummy_o && $stable(pc_o) && $stable(acc_o);
  endsequence

  incr_mem_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    live && instr_i.op == `CIJ_OP_INCR_MEM |=> mem_wr_o.we
      && mem_wr_o.data == 8'($past(mem_rdata_i) + 8'h01)
      && zero_o == (mem_wr_o.data == 8'h00))
    else $error("in-place increment wrong");
  incr_acc_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    live && instr_i.op == `CIJ_OP_INCR_ACC |=> acc_o == 8'($past(mem_rdata_i) + 8'h01)
      && zero_o == (acc_o == 8'h00))
    else $error("accumulator increment wrong");
  incr_nowr_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    live && instr_i.op == `CIJ_OP_INCR_ACC |=> !mem_wr_o.we)
    else $error("memory written on accumulator increment");
  jump_pc_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    jump_seen_s |=> pc_o == $past(instr_i.field) && $stable(zero_o) && $stable(acc_o))
    else $error("jump target or flags wrong");
  jump_dummy_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    jump_seen_s |=> dummy_slot_s)
    else $error("jump dummy slot wrong");
  dummy_hold_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    dummy_o |=> !dummy_o && !mem_wr_o.we && $stable(pc_o) && $stable(acc_o)
      && $stable(zero_o))
    else $error("dummy slot not idle");
  pc_step_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    live && instr_i.op != `CIJ_OP_JUMP |=> pc_o == 12'($past(pc_o) + 12'h001) && !dummy_o)
    else $error("program counter step wrong");
  mov_mem_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    live && instr_i.op == `CIJ_OP_MOV_MEM_ACC |=> acc_o == $past(mem_rdata_i) && $stable(zero_o))
    else $error("memory move wrong");
  mov_nowr_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    live && (instr_i.op == `CIJ_OP_MOV_MEM_ACC || instr_i.op == `CIJ_OP_MOV_IMM_ACC)
      |=> !mem_wr_o.we)
    else $error("memory written on accumulator move");
  mov_imm_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    live && instr_i.op == `CIJ_OP_MOV_IMM_ACC |=> acc_o == $past(instr_i.field[7:0])
      && $stable(zero_o))
    else $error("immediate move wrong");
  mov_store_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    live && instr_i.op == `CIJ_OP_MOV_ACC_MEM |=> mem_wr_o.we && mem_wr_o.data == $past(acc_o)
      && $stable(zero_o))
    else $error("accumulator store wrong");
  wr_addr_a: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    live && (instr_i.op == `CIJ_OP_INCR_MEM || instr_i.op == `CIJ_OP_MOV_ACC_MEM)
      |=> mem_wr_o.addr == $past(instr_i.field[7:0]) && $stable(acc_o))
    else $error("write address or accumulator wrong");
  // Reset clears every piece of state and drops any pending write.
  reset_clear_a: assert property (@(posedge mclk_i)
    !resetn_i |=> acc_o == `CIJ_ACC_RST && pc_o == `CIJ_PC_RST && !zero_o && !dummy_o
      && !mem_wr_o.we)
    else $error("reset state wrong");

endmodule : cij_exec

// *** cij_map.svh ***
`ifndef CIJ_MAP_SVH
`define CIJ_MAP_SVH
// Opcode field position in the 16-bit instruction word.
`define CIJ_OP_MSB 15
`define CIJ_OP_LSB 12
// Opcode encodings.
`define CIJ_OP_NOP 4'h0
`define CIJ_OP_INCR_MEM 4'h1
`define CIJ_OP_INCR_ACC 4'h2
`define CIJ_OP_JUMP 4'h3
`define CIJ_OP_MOV_MEM_ACC 4'h4
`define CIJ_OP_MOV_IMM_ACC 4'h5
`define CIJ_OP_MOV_ACC_MEM 4'h6
// Reset values.
`define CIJ_ACC_RST 8'h00
`define CIJ_PC_RST 12'h000
`endif

// *** cij_pkg.sv ***
package cij_pkg;
  // Decoded instruction word.
  typedef struct packed {
    logic [3:0] op;
    logic [11:0] field;
  } cij_instr_type;
  // Data memory write request.
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } cij_mem_wr_type;
  // Execution state.
  typedef enum logic [0:0] {
    CIJ_EXEC,
    CIJ_DUMMY
  } cij_state_type;
endpackage : cij_pkg

// *** tb.sv ***
`timescale 1ns/10ps
`include "cij_map.svh"
module tb;
  import cij_pkg::*;
  // Design ports.
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  cij_instr_type instr_i = '0;
  logic [7:0] mem_rdata_i, mem_addr_o, acc_o;
  cij_mem_wr_type mem_wr_o;
  logic zero_o, dummy_o;
  logic [11:0] pc_o;
  int errors = 0;
  int cmp_count = 0;
  int seed = 48877;
  // Bench memory and model state.
  logic [7:0] mem [256];
  logic [7:0] acc, rd;
  logic z, dm;
  logic [11:0] pc;
  cij_mem_wr_type ew;
  always #2 mclk_i = ~mclk_i;
  // Reads see the bench memory at the addressed byte.
  assign mem_rdata_i = mem[instr_i.field[7:0]];
  cij_exec dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .instr_i(instr_i),
    .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o), .mem_wr_o(mem_wr_o),
    .acc_o(acc_o), .zero_o(zero_o), .pc_o(pc_o), .dummy_o(dummy_o));
  // Counts one comparison and reports a mismatch.
  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic final_report;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    // Odd bytes hold ff so increments often wrap to zero.
    for (int i = 0; i < 256; i++) mem[i] = i[0] ? 8'hff : 8'($random(seed));
    acc = 8'h00;
    z = 1'b0;
    pc = 12'h000;
    dm = 1'b0;
    ew = '0;
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 3000; i++) begin
      if (i == 1500) begin
        // Mid-run reset: a pending write still lands, then all state clears.
        resetn_i = 1'b0;
        @(posedge mclk_i);
        if (ew.we) mem[ew.addr] <= ew.data;
        repeat (2) @(negedge mclk_i);
        resetn_i = 1'b1;
        acc = `CIJ_ACC_RST;
        z = 1'b0;
        pc = `CIJ_PC_RST;
        dm = 1'b0;
        ew.we = 1'b0;
        chk("rst pc", 17'(pc), 17'(pc_o));
        chk("rst acc", 17'({acc, z}), 17'({acc_o, zero_o}));
      end
      instr_i = {4'($random(seed) & 7), 12'($random(seed))};
      #1 chk("addr", 17'(instr_i.field[7:0]), 17'(mem_addr_o));
      @(posedge mclk_i);
      rd = mem[instr_i.field[7:0]];
      // The write lands one edge after it is issued, after the design sampled.
      if (ew.we) mem[ew.addr] <= ew.data;
      ew.we = 1'b0;
      if (dm) begin
        dm = 1'b0;
      end else begin
        pc = pc + 12'h001;
        case (instr_i.op)
          `CIJ_OP_INCR_MEM: begin
            ew = {1'b1, instr_i.field[7:0], rd + 8'h01};
            z = (rd == 8'hff);
          end
          `CIJ_OP_INCR_ACC: begin
            acc = rd + 8'h01;
            z = (rd == 8'hff);
          end
          `CIJ_OP_JUMP: begin
            pc = instr_i.field;
            dm = 1'b1;
          end
          `CIJ_OP_MOV_MEM_ACC: acc = rd;
          `CIJ_OP_MOV_IMM_ACC: acc = instr_i.field[7:0];
          `CIJ_OP_MOV_ACC_MEM: ew = {1'b1, instr_i.field[7:0], acc};
          default: ;
        endcase
      end
      @(negedge mclk_i);
      chk("acc", 17'(acc), 17'(acc_o));
      chk("zero", 17'(z), 17'(zero_o));
      chk("pc", 17'(pc), 17'(pc_o));
      chk("dummy", 17'(dm), 17'(dummy_o));
      chk("we", 17'(ew.we), 17'(mem_wr_o.we));
      if (ew.we) chk("write", ew, mem_wr_o);
    end
    final_report();
  end
endmodule : tb
